// [src/timer16_output_compare.sv]
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module timer16_output_compare (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // timer tick and capture value
    input wire logic timer_tick_i,
    input wire logic [15:0] capture_value_i,
    // interrupt request and service
    output logic [1:0] irq_o,
    input wire logic [1:0] irq_ack_i,
    // port override
    input wire logic [1:0] port_data_i,
    input wire logic [1:0] output_pin_direction_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o,
    // counter indications
    output logic top_o,
    output logic bottom_o
);
    ocmp_pkg::ctrl_type ctrl_q;
    logic [1:0] irq_en_q;
    logic [1:0] compare_match_flag_q;
    logic [1:0] compare_output_bit_q;
    logic [15:0] timer_count_q;
    logic [7:0] temp_q;
    logic [15:0] cmp_buf_q [ocmp_pkg::NCH];
    logic [15:0] cmp_act_q [ocmp_pkg::NCH];
    logic [1:0] pend_q;
    logic [1:0] pend_dn_q;
    logic block_q;
    logic down_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    logic setup_rd, acc_wr, tick;
    logic [1:0] actions [ocmp_pkg::NCH];
    logic [15:0] top_val;
    logic is_pwm, is_dual, upd_at_top, var_top;
    logic at_top, at_bottom;
    logic [1:0] match_now;
    logic [1:0] force_req;
    logic wr_cnt_lo, wr_cnt_hi, wr_flags;
    logic [1:0] wr_cmp_lo, wr_cmp_hi;
    logic [31:0] rd_data;
    logic rd_err;

    assign tick = ce_i & timer_tick_i;
    assign setup_rd = ce_i & psel_i & ~penable_i & ~pwrite_i;
    assign acc_wr = ce_i & psel_i & penable_i & pwrite_i;
    assign actions[0] = ctrl_q.action_a;
    assign actions[1] = ctrl_q.action_b;

    // mode decode: top source, pwm class, buffer update point
    always_comb begin
        top_val = ocmp_pkg::TOP_MAX;
        is_pwm = 1'b1;
        is_dual = 1'b0;
        upd_at_top = 1'b0;
        var_top = 1'b0;
        case (ctrl_q.waveform_mode_sel)
            ocmp_pkg::MODE_NORMAL: begin
                is_pwm = 1'b0; // [R23]
            end
            ocmp_pkg::MODE_CTC_A: begin
                is_pwm = 1'b0;
                top_val = cmp_act_q[0]; // [R24] [R5]
            end
            ocmp_pkg::MODE_CTC_CAP: begin
                is_pwm = 1'b0;
                top_val = capture_value_i; // [R24]
            end
            ocmp_pkg::MODE_RSVD: begin
                is_pwm = 1'b0;
            end
            ocmp_pkg::MODE_PC8, ocmp_pkg::MODE_FAST8: begin
                top_val = ocmp_pkg::TOP_8BIT;
            end
            ocmp_pkg::MODE_PC9, ocmp_pkg::MODE_FAST9: begin
                top_val = ocmp_pkg::TOP_9BIT;
            end
            ocmp_pkg::MODE_PC10, ocmp_pkg::MODE_FAST10: begin
                top_val = ocmp_pkg::TOP_10BIT;
            end
            ocmp_pkg::MODE_PFC_CAP, ocmp_pkg::MODE_PC_CAP, ocmp_pkg::MODE_FAST_CAP: begin
                top_val = capture_value_i;
                var_top = 1'b1;
            end
            default: begin
                top_val = cmp_act_q[0]; // [R5]
                var_top = 1'b1;
            end
        endcase
        case (ctrl_q.waveform_mode_sel)
            ocmp_pkg::MODE_PC8, ocmp_pkg::MODE_PC9, ocmp_pkg::MODE_PC10,
            ocmp_pkg::MODE_PC_CAP, ocmp_pkg::MODE_PC_A: begin
                is_dual = 1'b1;
                upd_at_top = 1'b1;
            end
            ocmp_pkg::MODE_PFC_CAP, ocmp_pkg::MODE_PFC_A: begin
                is_dual = 1'b1;
            end
            default: begin
                is_dual = 1'b0;
            end
        endcase
    end

    // extreme values; a blocked match also hides a variable top
    always_comb begin
        at_bottom = (timer_count_q == ocmp_pkg::CNT_ZERO); // [R22]
        at_top = (timer_count_q == top_val) & ~(block_q & var_top); // [R22] [R14]
        for (int i = 0; i < ocmp_pkg::NCH; i++) begin
            match_now[i] = (timer_count_q == cmp_act_q[i]) & ~block_q; // [R1] [R13]
        end
    end

    assign top_o = at_top;
    assign bottom_o = at_bottom;

    // write decode
    always_comb begin
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        wr_flags = 1'b0;
        wr_cmp_lo = 2'b00;
        wr_cmp_hi = 2'b00;
        force_req = 2'b00;
        if (acc_wr && paddr_i == ocmp_pkg::ADDR_CNT_LO) begin
            wr_cnt_lo = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CNT_HI) begin
            wr_cnt_hi = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_FLAGS) begin
            wr_flags = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_FORCE) begin
            force_req = pwdata_i[1:0] & {2{~is_pwm}}; // [R12]
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CMPA_LO) begin
            wr_cmp_lo[0] = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CMPA_HI) begin
            wr_cmp_hi[0] = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CMPB_LO) begin
            wr_cmp_lo[1] = 1'b1;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CMPB_HI) begin
            wr_cmp_hi[1] = 1'b1;
        end
    end

    // read decode; compare high reads bypass the shared latch
    always_comb begin
        rd_data = ocmp_pkg::RDATA_ZERO;
        rd_err = 1'b0;
        if (paddr_i == ocmp_pkg::ADDR_CTRL) begin
            rd_data[ocmp_pkg::CTRL_W-1:0] = ctrl_q;
        end else if (paddr_i == ocmp_pkg::ADDR_IRQ_EN) begin
            rd_data[1:0] = irq_en_q;
        end else if (paddr_i == ocmp_pkg::ADDR_FLAGS) begin
            rd_data[1:0] = compare_match_flag_q;
        end else if (paddr_i == ocmp_pkg::ADDR_FORCE) begin
            rd_data[1:0] = 2'b00; // strobes read as zero
        end else if (paddr_i == ocmp_pkg::ADDR_CNT_LO) begin
            rd_data[7:0] = timer_count_q[7:0];
        end else if (paddr_i == ocmp_pkg::ADDR_CNT_HI) begin
            rd_data[7:0] = temp_q;
        end else if (paddr_i == ocmp_pkg::ADDR_CMPA_LO) begin
            rd_data[7:0] = cmp_buf_q[0][7:0]; // [R8]
        end else if (paddr_i == ocmp_pkg::ADDR_CMPA_HI) begin
            rd_data[7:0] = cmp_buf_q[0][15:8]; // [R9]
        end else if (paddr_i == ocmp_pkg::ADDR_CMPB_LO) begin
            rd_data[7:0] = cmp_buf_q[1][7:0]; // [R8]
        end else if (paddr_i == ocmp_pkg::ADDR_CMPB_HI) begin
            rd_data[7:0] = cmp_buf_q[1][15:8]; // [R9]
        end else if (paddr_i == ocmp_pkg::ADDR_STATUS) begin
            rd_data[1:0] = compare_output_bit_q;
        end else begin
            rd_err = 1'b1;
        end
    end

    // read data is captured in the setup cycle so the answer has no wait state
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_q <= ocmp_pkg::RDATA_ZERO;
            pslverr_q <= 1'b0;
        end else if (ce_i && psel_i && !penable_i) begin
            prdata_q <= pwrite_i ? ocmp_pkg::RDATA_ZERO : rd_data;
            pslverr_q <= rd_err;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = pslverr_q & psel_i & penable_i;

    // control and enable registers; action bits act directly, unbuffered
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= ocmp_pkg::CTRL_RESET;
            irq_en_q <= 2'b00;
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_CTRL) begin
            ctrl_q <= pwdata_i[ocmp_pkg::CTRL_W-1:0]; // [R16]
        end else if (acc_wr && paddr_i == ocmp_pkg::ADDR_IRQ_EN) begin
            irq_en_q <= pwdata_i[1:0];
        end
    end

    // shared high-byte latch for count and compare writes, count-low reads
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_q <= 8'h00;
        end else if (wr_cnt_hi || (|wr_cmp_hi)) begin
            temp_q <= pwdata_i[7:0]; // [R10]
        end else if (setup_rd && paddr_i == ocmp_pkg::ADDR_CNT_LO) begin
            temp_q <= timer_count_q[15:8];
        end
    end

    // compare registers: cpu write only, buffered in pwm modes
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < ocmp_pkg::NCH; i++) begin
                cmp_buf_q[i] <= ocmp_pkg::CNT_ZERO;
                cmp_act_q[i] <= ocmp_pkg::CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < ocmp_pkg::NCH; i++) begin
                if (wr_cmp_lo[i]) begin
                    cmp_buf_q[i] <= {temp_q, pwdata_i[7:0]}; // [R10] [R9] [R11]
                    if (!is_pwm) begin
                        cmp_act_q[i] <= {temp_q, pwdata_i[7:0]}; // [R8] [R6]
                    end
                end else if (tick && is_pwm && (upd_at_top ? at_top : at_bottom)) begin
                    cmp_act_q[i] <= cmp_buf_q[i]; // [R6] [R7]
                end
            end
        end
    end

    // counter; a cpu write wins over clear and count
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_count_q <= ocmp_pkg::CNT_ZERO;
            down_q <= 1'b0;
        end else if (wr_cnt_lo) begin
            timer_count_q <= {temp_q, pwdata_i[7:0]};
        end else if (tick) begin
            if (!is_dual) begin
                down_q <= 1'b0;
                if (ctrl_q.waveform_mode_sel != ocmp_pkg::MODE_NORMAL && at_top) begin
                    timer_count_q <= ocmp_pkg::CNT_ZERO; // [R24]
                end else begin
                    timer_count_q <= timer_count_q + ocmp_pkg::CNT_ONE; // [R23] [R14]
                end
            end else if (!down_q && at_top) begin
                down_q <= 1'b1;
                timer_count_q <= timer_count_q - ocmp_pkg::CNT_ONE;
            end else if (down_q && at_bottom) begin
                down_q <= 1'b0;
                timer_count_q <= timer_count_q + ocmp_pkg::CNT_ONE;
            end else if (down_q) begin
                timer_count_q <= timer_count_q - ocmp_pkg::CNT_ONE;
            end else begin
                timer_count_q <= timer_count_q + ocmp_pkg::CNT_ONE;
            end
        end
    end

    // match blocking: set by any count write, spent by the next tick
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            block_q <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_q <= 1'b1; // [R13]
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // matches are held one tick before they reach flags and outputs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= 2'b00;
            pend_dn_q <= 2'b00;
        end else if (tick) begin
            pend_q <= match_now; // [R2]
            pend_dn_q <= {2{down_q}};
        end
    end

    // flags: hardware set wins over software and service clears
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            compare_match_flag_q <= 2'b00;
        end else begin
            for (int i = 0; i < ocmp_pkg::NCH; i++) begin
                if (tick && pend_q[i]) begin
                    compare_match_flag_q[i] <= 1'b1; // [R2]
                end else if (irq_ack_i[i] && ce_i) begin
                    compare_match_flag_q[i] <= 1'b0; // [R3]
                end else if (wr_flags && pwdata_i[i]) begin
                    compare_match_flag_q[i] <= 1'b0; // [R4]
                end
            end
        end
    end

    assign irq_o = compare_match_flag_q & irq_en_q; // [R3]

    // waveform output; mode changes leave the bit alone
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            compare_output_bit_q <= 2'b00; // [R17]
        end else begin
            for (int i = 0; i < ocmp_pkg::NCH; i++) begin
                if (force_req[i] || (tick && pend_q[i] && !is_pwm)) begin
                    // non-pwm: toggle, clear or set on match or force
                    case (actions[i])
                        ocmp_pkg::ACT_TOGGLE: compare_output_bit_q[i] <= ~compare_output_bit_q[i];
                        ocmp_pkg::ACT_CLEAR: compare_output_bit_q[i] <= 1'b0;
                        ocmp_pkg::ACT_SET: compare_output_bit_q[i] <= 1'b1;
                        default: compare_output_bit_q[i] <= compare_output_bit_q[i]; // [R20]
                    endcase // [R12] [R15]
                end else if (tick && pend_q[i]) begin
                    // pwm match: clear or set, flipped on the down slope; channel A toggles when top is variable
                    if (actions[i] == ocmp_pkg::ACT_CLEAR) begin
                        compare_output_bit_q[i] <= pend_dn_q[i];
                    end else if (actions[i] == ocmp_pkg::ACT_SET) begin
                        compare_output_bit_q[i] <= ~pend_dn_q[i];
                    end else if (actions[i] == ocmp_pkg::ACT_TOGGLE && i == 0 && var_top) begin
                        compare_output_bit_q[i] <= ~compare_output_bit_q[i];
                    end
                end else if (tick && is_pwm && !is_dual && at_bottom) begin
                    // fast pwm restores the idle level at bottom
                    if (actions[i] == ocmp_pkg::ACT_CLEAR) begin
                        compare_output_bit_q[i] <= 1'b1;
                    end else if (actions[i] == ocmp_pkg::ACT_SET) begin
                        compare_output_bit_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // pin override; direction always from the port, capture path untouched
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o <= 2'b00;
            pin_oe_o <= 2'b00;
        end else if (ce_i) begin
            for (int i = 0; i < ocmp_pkg::NCH; i++) begin
                pin_o[i] <= (actions[i] != ocmp_pkg::ACT_NONE) ?
                    compare_output_bit_q[i] : port_data_i[i]; // [R18] [R21]
            end
            pin_oe_o <= output_pin_direction_i; // [R18] [R19]
        end
    end
endmodule

// [src/ocmp_pkg.sv]
// How it works
// R1 - both channels compare the full 16-bit count with their compare value continuously
// R2 - a match sets the channel match flag one timer tick later
// R3 - flag with its enable set raises an interrupt; servicing it clears the flag
// R4 - writing one to a flag bit clears it; zero leaves it alone
// R5 - channel A compare value can serve as counter top, fixing period
// R6 - compare value double buffered in the twelve pwm modes, direct otherwise
// R7 - buffered value moves to the active compare only at top or bottom
// R8 - cpu compare access hits the buffer when buffered, the active register otherwise
// R9 - only cpu writes change compare; high byte reads return the register itself
// R10 - high byte write loads the shared latch; low write commits all 16 bits
// R11 - software writes the high byte before the low byte
// R12 - force strobe in non-pwm modes acts on the output only, no flag
// R13 - any count write blocks compare matches in the next timer tick
// R14 - writing count equal to variable top loses the top match
// R15 - compare output bit keeps its value across waveform mode changes
// R16 - action bits are not buffered; they act from the next match
// R17 - reset clears the compare output bits to zero
// R18 - nonzero action routes the compare output to the pin; direction stays external
// R19 - software sets pin direction to output, ideally after setting output state
// R20 - action zero leaves the compare output unchanged on a match
// R21 - action bits have no influence on input capture
// R22 - counter supplies top and bottom indications every timer tick
// R23 - mode zero counts up only and never clears
// R24 - modes four and twelve clear on match with channel A or capture
package ocmp_pkg;
    localparam int CW = 16;
    localparam int NCH = 2;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_FORCE = 8'h0C;
    localparam logic [7:0] ADDR_CNT_LO = 8'h10;
    localparam logic [7:0] ADDR_CNT_HI = 8'h14;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h18;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h1C;
    localparam logic [7:0] ADDR_CMPB_LO = 8'h20;
    localparam logic [7:0] ADDR_CMPB_HI = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] CMP_STRIDE = 8'h08;
    // fixed counts
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // waveform mode encodings
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0000, MODE_PC8 = 4'b0001, MODE_PC9 = 4'b0010,
        MODE_PC10 = 4'b0011, MODE_CTC_A = 4'b0100, MODE_FAST8 = 4'b0101,
        MODE_FAST9 = 4'b0110, MODE_FAST10 = 4'b0111, MODE_PFC_CAP = 4'b1000,
        MODE_PFC_A = 4'b1001, MODE_PC_CAP = 4'b1010, MODE_PC_A = 4'b1011,
        MODE_CTC_CAP = 4'b1100, MODE_RSVD = 4'b1101, MODE_FAST_CAP = 4'b1110,
        MODE_FAST_A = 4'b1111
    } wave_mode_type;

    // compare output action encodings
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // control register layout, high bits first
    typedef struct packed {
        logic [1:0] action_b;
        logic [1:0] action_a;
        wave_mode_type waveform_mode_sel;
    } ctrl_type;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// [verification/timer16_output_compare_monitor.sv]
`timescale 1ns/1ps
module timer16_output_compare_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pslverr_o,
    // timer, interrupts, pins
    input wire logic timer_tick_i,
    input wire logic [1:0] irq_o,
    input wire logic [1:0] irq_ack_i,
    input wire logic [1:0] port_data_i,
    input wire logic [1:0] output_pin_direction_i,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic wr_en;
    logic [3:0] act_q;
    assign wr_en = psel_i && penable_i && pwrite_i && ce_i;
    // shadow of the action bits, to judge port pass-through
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_q <= 4'h0;
        end else if (wr_en && paddr_i == ocmp_pkg::ADDR_CTRL) begin
            act_q <= pwdata_i[7:4];
        end
    end
    function automatic logic unmapped(input logic [7:0] a);
        return a[1:0] != 2'b00 || a > ocmp_pkg::ADDR_STATUS;
    endfunction
    sequence s_setup;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    a_slverr_decode: assert property (s_setup ##1 s_access |-> pslverr_o == unmapped(paddr_i))
        else $error("slverr vs decode");
    a_flag_clear_one: assert property (
        wr_en && paddr_i == ocmp_pkg::ADDR_FLAGS && pwdata_i[1:0] == 2'b11 && !timer_tick_i
        |=> irq_o == 2'b00) else $error("w1c failed");
    a_flag_keep_zero: assert property (
        wr_en && paddr_i == ocmp_pkg::ADDR_FLAGS && pwdata_i[1:0] == 2'b00 && !timer_tick_i
        && irq_ack_i == 2'b00 |=> $stable(irq_o)) else $error("zero write changed flags");
    a_ack_clears: assert property (ce_i && irq_ack_i[1] && !timer_tick_i |=> !irq_o[1])
        else $error("ack kept flag b");
    a_irq_en_off: assert property (
        wr_en && paddr_i == ocmp_pkg::ADDR_IRQ_EN && pwdata_i[1:0] == 2'b00 |=> irq_o == 2'b00)
        else $error("irq with enable off");
    a_irq_rise_cause: assert property ((irq_o & ~$past(irq_o)) != 2'b00 |->
        $past(ce_i && timer_tick_i) || $past(wr_en && paddr_i == ocmp_pkg::ADDR_IRQ_EN))
        else $error("irq rose without tick");
    a_oe_follows: assert property (ce_i |=> pin_oe_o == $past(output_pin_direction_i))
        else $error("oe not direction");
    a_port_pass_a: assert property (ce_i && act_q[1:0] == 2'b00 |=> pin_o[0] == $past(port_data_i[0]))
        else $error("pin a not port data");
    a_port_pass_b: assert property (ce_i && act_q[3:2] == 2'b00 |=> pin_o[1] == $past(port_data_i[1]))
        else $error("pin b not port data");
endmodule

// [verification/timer16_output_compare_tb_top.sv]
`timescale 1ns/1ps
module timer16_output_compare_tb_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic timer_tick_i = 1'b0;
    logic [15:0] capture_value_i = 16'h8000;
    logic [1:0] irq_ack_i = 2'b00;
    logic [1:0] port_data_i = 2'b00;
    logic [1:0] output_pin_direction_i = 2'b00;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, top_o, bottom_o;
    logic [1:0] irq_o, pin_o, pin_oe_o;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int nb, nt;
    logic [31:0] seed = 32'hedad_1199;
    logic [31:0] pseed = 32'hedad_1199;
    logic [31:0] rd;
    logic er;
    logic [7:0] c;
    logic [1:0] oc = 2'b00;

    timer16_output_compare timer16_output_compare_inst (.*);

    always #4 clock_i = ~clock_i;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // next output bit on a match in non-pwm modes
    function automatic logic act(input logic b, input logic [1:0] a);
        case (a)
            ocmp_pkg::ACT_TOGGLE: return !b;
            ocmp_pkg::ACT_CLEAR: return 1'b0;
            ocmp_pkg::ACT_SET: return 1'b1;
            default: return b;
        endcase
    endfunction

    // random port data and direction every cycle, plus the hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        pseed <= xs(pseed);
        port_data_i <= pseed[1:0];
        output_pin_direction_i <= pseed[3:2];
        if (cycles == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer; a dead slave is caught by the bench timeout
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) begin
            @(posedge clock_i);
        end
        chk(pready_o, 1'b1, "pready");
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e, m);
    endtask
    // high byte first, low byte commits both
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h04, {24'h00_0000, v[15:8]});
        wr(lo, {24'h00_0000, v[7:0]});
    endtask
    // tick pulses, then let registered pins settle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock_i);
            timer_tick_i <= 1'b1;
            @(posedge clock_i);
            timer_tick_i <= 1'b0;
        end
        repeat (2) @(negedge clock_i);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        #1 chk(bottom_o, 1'b1, "bottom after reset");
        rdx(ocmp_pkg::ADDR_STATUS, 32'h0000_0000, "status reset");
        $display("test reset finished");
        seed = xs(seed);
        wr(ocmp_pkg::ADDR_CTRL, {24'h00_0000, seed[7:0]});
        rdx(ocmp_pkg::ADDR_CTRL, {24'h00_0000, seed[7:0]}, "ctrl readback");
        wr16(ocmp_pkg::ADDR_CMPB_LO, seed[23:8]);
        rdx(ocmp_pkg::ADDR_CMPB_HI, {24'h00_0000, seed[23:16]}, "compare high");
        rdx(ocmp_pkg::ADDR_CMPB_LO, {24'h00_0000, seed[15:8]}, "compare low");
        wr(ocmp_pkg::ADDR_STATUS, 32'h0000_0003);
        rdx(ocmp_pkg::ADDR_STATUS, 32'h0000_0000, "status ro");
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped data");
        chk(er, 1'b1, "unmapped error");
        ce_i <= 1'b0;
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_0000);
        ce_i <= 1'b1;
        rdx(ocmp_pkg::ADDR_CTRL, {24'h00_0000, seed[7:0]}, "frozen write");
        $display("test registers finished");
        seed = xs(seed);
        c = {5'h00, seed[2:0]} + 8'h02;
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_00D0);
        wr16(ocmp_pkg::ADDR_CMPA_LO, {8'h00, c});
        wr16(ocmp_pkg::ADDR_CMPB_LO, {8'h00, c} + 16'h0002);
        wr16(ocmp_pkg::ADDR_CNT_LO, 16'h0000);
        wr(ocmp_pkg::ADDR_FLAGS, 32'h0000_0003);
        wr(ocmp_pkg::ADDR_IRQ_EN, 32'h0000_0003);
        ticks(int'(c) + 1);
        chk(irq_o, 2'b00, "flag early");
        ticks(1);
        oc[0] = act(oc[0], ocmp_pkg::ACT_TOGGLE);
        chk(irq_o, 2'b01, "flag a");
        chk(pin_o[0], oc[0], "pin a override");
        ticks(2);
        oc[1] = act(oc[1], ocmp_pkg::ACT_SET);
        chk(irq_o, 2'b11, "flag b");
        rdx(ocmp_pkg::ADDR_STATUS, {30'h0, oc}, "outputs after match");
        wr(ocmp_pkg::ADDR_FLAGS, 32'h0000_0001);
        chk(irq_o, 2'b10, "write one clears");
        wr(ocmp_pkg::ADDR_FLAGS, 32'h0000_0000);
        chk(irq_o, 2'b10, "write zero keeps");
        @(posedge clock_i);
        irq_ack_i <= 2'b10;
        @(posedge clock_i);
        irq_ack_i <= 2'b00;
        #1 chk(irq_o, 2'b00, "service clears");
        $display("test match finished");
        // count written onto the compare value hides that match
        wr16(ocmp_pkg::ADDR_CNT_LO, {8'h00, c});
        ticks(3);
        chk(irq_o, 2'b00, "blocked match");
        wr(ocmp_pkg::ADDR_FORCE, 32'h0000_0001);
        oc[0] = act(oc[0], ocmp_pkg::ACT_TOGGLE);
        rdx(ocmp_pkg::ADDR_STATUS, {30'h0, oc}, "forced toggle");
        chk(irq_o, 2'b00, "force sets no flag");
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_00C0);
        wr(ocmp_pkg::ADDR_FORCE, 32'h0000_0001);
        rdx(ocmp_pkg::ADDR_STATUS, {30'h0, oc}, "action none");
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_00C5);
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_00C0);
        rdx(ocmp_pkg::ADDR_STATUS, {30'h0, oc}, "mode change keeps bits");
        $display("test blocking and force finished");
        wr(ocmp_pkg::ADDR_CTRL, 32'h0000_0004);
        wr16(ocmp_pkg::ADDR_CMPA_LO, {8'h00, c});
        wr16(ocmp_pkg::ADDR_CNT_LO, 16'h0000);
        nb = 0;
        nt = 0;
        repeat (4 * (int'(c) + 1)) begin
            ticks(1);
            nb += int'(bottom_o === 1'b1);
            nt += int'(top_o === 1'b1);
        end
        chk(nb, 4, "periods");
        chk(nt, 4, "tops");
        $display("test clear on match finished");
        close_out();
    end
endmodule

bind timer16_output_compare timer16_output_compare_monitor timer16_output_compare_monitor_inst (.*);
